// ---- design/cdr_regs_pkg.sv ----
package cdr_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FREQ_LOW   = 8'h00;
  localparam logic [7:0] OFS_FREQ_MID   = 8'h01;
  localparam logic [7:0] OFS_FREQ_HIGH  = 8'h02;
  localparam logic [7:0] OFS_COARSE     = 8'h03;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_RATE_CTRL  = 8'h08;
  localparam logic [7:0] OFS_LOCK_CTRL  = 8'h09;
  localparam logic [7:0] OFS_OUT_CFG    = 8'h11;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_LOS_BIT      = 5;
  localparam int ST_STATIC_BIT   = 4;
  localparam int ST_LIVE_BIT     = 3;
  localparam int ST_MDONE_BIT    = 2;
  localparam int ST_COARSE0_BIT  = 0;
  localparam int RC_BAND_HI      = 7;
  localparam int RC_BAND_LO      = 6;
  localparam int RC_EXP_HI       = 5;
  localparam int RC_EXP_LO       = 2;
  localparam int RC_MEASURE_BIT  = 1;
  localparam int RC_LOCKREF_BIT  = 0;
  localparam int LC_CFG_LOL_BIT  = 7;
  localparam int LC_CLR_STAT_BIT = 6;
  localparam int LC_SYSRST_BIT   = 5;
  localparam int LC_CLR_MEAS_BIT = 3;
  localparam int OC_LOS_POL_BIT  = 2;
  localparam int OC_SQ_MODE_BIT  = 1;

  // ----------------------------------------------------------------
  // lock detector thresholds
  // ----------------------------------------------------------------
  localparam logic [15:0] UNLOCK_PPM    = 16'h03e8;
  localparam logic [15:0] RELOCK_PPM    = 16'h00fa;

  // ----------------------------------------------------------------
  // serial port address, upper and lower parts (arbitrary values)
  // ----------------------------------------------------------------
  localparam logic [1:0] SLAVE_ADDR_HI  = 2'h1;
  localparam logic [3:0] SLAVE_ADDR_LO  = 4'h0;

  typedef struct packed {
    logic [22:0] freq;
    logic [8:0]  coarse;
  } rate_meas_t;

  typedef struct packed {
    logic signal_absent_out;
    logic static_lol;
    logic live_lol;
    logic meas_done;
  } status_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_BUSY = 3'b010,
    MS_DONE = 3'b100
  } meas_state_t;

  typedef enum logic [6:0] {
    SS_IDLE = 7'b0000001,
    SS_ADDR = 7'b0000010,
    SS_SUB  = 7'b0000100,
    SS_WR   = 7'b0001000,
    SS_ACK  = 7'b0010000,
    SS_RD   = 7'b0100000,
    SS_RACK = 7'b1000000
  } serial_state_t;

endpackage

// ---- design/cdr_register_bank.sv ----
// Notes on behaviour
// - coarse rate bits 8..1 read at 0x3, bit 0 in status D0.
// - status D5 is 1 while signal is lost, else 0.
// - status D4 latches on loss of lock; D3 is live lock state.
// - status D2 is 0 while measuring, 1 once measurement completes.
// - rate control D5:D2 give exponent n of ratio 2 to the n.
// - writing 1 to rate control D1 starts a rate measurement.
// - rate control D0 locks loop to data (0) or reference (1).
// - lock control D7 makes unlocked indicator live (0) or latched (1).
// - writing 1 then 0 clears D4, clears D2, or resets control registers, D4 and D2 and pulses system reset.
// - output config D2 sets signal-lost pin high (0) or low active.
// - output config D1 squelches clock and data, or data only.
// - all writeable control registers hold 0x00 after reset.
// - unlock above 1000 ppm error, relock once within 250 ppm.
// - mute pin high disables outputs per the squelch mode.
// - signal-lost pin shows loss of input, active high by default.
`timescale 1ns/10ps
module cdr_register_bank (
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  input  wire logic                      slave_addr_bit5_pin_i,
  input  wire logic                      mute_i,
  input  wire logic                      signal_lost_i,
  input  wire logic [15:0]               freq_err_ppm_i,
  input  wire logic                      meas_done_i,
  input  wire cdr_regs_pkg::rate_meas_t  meas_i,
  output logic                           meas_start_o,
  output logic [1:0]                     refclk_band_o,
  output logic [3:0]                     ratio_exp_o,
  output logic                           lock_to_ref_o,
  output logic                           unlocked_indicator_o,
  output logic                           signal_absent_out_o,
  output logic                           clk_out_en_o,
  output logic                           data_out_en_o,
  output logic                           system_reset_o
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [1:0] bus_prev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // bus lines idle high, mute and signal loss idle low
      sync1    <= 5'h1c;
      sync2    <= 5'h1c;
      bus_prev <= 2'h3;
    end else begin
      sync1    <= {scl_i, sda_i, slave_addr_bit5_pin_i, mute_i,
                   signal_lost_i};
      sync2    <= sync1;
      bus_prev <= sync2[4:3];
    end
  end

  logic scl;
  logic sda;
  logic addr5;
  logic mute;
  logic signal_absent_out;
  assign scl   = sync2[4];
  assign sda   = sync2[3];
  assign addr5 = sync2[2];
  assign mute  = sync2[1];
  assign signal_absent_out   = sync2[0];

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = scl & ~bus_prev[1];
  assign scl_fall   = ~scl & bus_prev[1];
  assign start_cond = scl & bus_prev[1] & bus_prev[0] & ~sda;
  assign stop_cond  = scl & bus_prev[1] & ~bus_prev[0] & sda;

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [7:0]                  rate_control;
  logic [7:0]                  lock_reset_control;
  logic [7:0]                  output_config;
  cdr_regs_pkg::rate_meas_t    meas_held;
  cdr_regs_pkg::status_t       status;
  cdr_regs_pkg::meas_state_t   meas_state;

  logic [7:0] rd_byte;
  logic [7:0] ptr;

  // readback mux; unmapped and write-only offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr == cdr_regs_pkg::OFS_FREQ_LOW) begin
      rd_byte = meas_held.freq[7:0];
    end else if (ptr == cdr_regs_pkg::OFS_FREQ_MID) begin
      rd_byte = meas_held.freq[15:8];
    end else if (ptr == cdr_regs_pkg::OFS_FREQ_HIGH) begin
      rd_byte = {1'b0, meas_held.freq[22:16]};
    end else if (ptr == cdr_regs_pkg::OFS_COARSE) begin
      rd_byte = meas_held.coarse[8:1];
    end else if (ptr == cdr_regs_pkg::OFS_STATUS) begin
      rd_byte = 8'h00;
      rd_byte[cdr_regs_pkg::ST_LOS_BIT]     = status.signal_absent_out;
      rd_byte[cdr_regs_pkg::ST_STATIC_BIT]  = status.static_lol;
      rd_byte[cdr_regs_pkg::ST_LIVE_BIT]    = status.live_lol;
      rd_byte[cdr_regs_pkg::ST_MDONE_BIT]   = status.meas_done;
      rd_byte[cdr_regs_pkg::ST_COARSE0_BIT] = meas_held.coarse[0];
    end
  end

  // --------------------------------------------------------------
  // serial slave
  // --------------------------------------------------------------
  cdr_regs_pkg::serial_state_t ss;
  cdr_regs_pkg::serial_state_t next_ss;
  cdr_regs_pkg::serial_state_t ack_to;
  cdr_regs_pkg::serial_state_t next_ack_to;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] next_ptr;
  logic       next_sda_oe;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] my_addr;

  assign my_addr = {cdr_regs_pkg::SLAVE_ADDR_HI, addr5,
                    cdr_regs_pkg::SLAVE_ADDR_LO};

  always_comb begin
    next_ss     = ss;
    next_ack_to = ack_to;
    next_shift  = shift;
    next_cnt    = cnt;
    next_ptr    = ptr;
    next_sda_oe = sda_oe_o;
    wr_en       = 1'b0;
    wr_addr     = ptr;
    wr_data     = shift;
    if (start_cond) begin
      next_ss     = cdr_regs_pkg::SS_ADDR;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_ss     = cdr_regs_pkg::SS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (ss)
        cdr_regs_pkg::SS_ADDR, cdr_regs_pkg::SS_SUB,
        cdr_regs_pkg::SS_WR: begin
          if (scl_rise && cnt != 4'h8) begin
            next_shift = {shift[6:0], sda};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt    = 4'h0;
            next_ss     = cdr_regs_pkg::SS_ACK;
            next_sda_oe = 1'b1;
            if (ss == cdr_regs_pkg::SS_ADDR) begin
              next_ack_to = shift[0] ? cdr_regs_pkg::SS_RD
                                     : cdr_regs_pkg::SS_SUB;
              if (shift[7:1] != my_addr) begin
                next_ss     = cdr_regs_pkg::SS_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (ss == cdr_regs_pkg::SS_SUB) begin
              next_ptr    = shift;
              next_ack_to = cdr_regs_pkg::SS_WR;
            end else begin
              wr_en       = 1'b1;
              next_ptr    = ptr + 8'h01;
              next_ack_to = cdr_regs_pkg::SS_WR;
            end
          end
        end
        cdr_regs_pkg::SS_ACK: begin
          if (scl_fall) begin
            next_ss     = ack_to;
            next_sda_oe = 1'b0;
            if (ack_to == cdr_regs_pkg::SS_RD) begin
              next_sda_oe = ~rd_byte[7];
              next_shift  = {rd_byte[6:0], 1'b0};
              next_cnt    = 4'h1;
              next_ptr    = ptr + 8'h01;
            end
          end
        end
        cdr_regs_pkg::SS_RD: begin
          if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_ss     = cdr_regs_pkg::SS_RACK;
              next_sda_oe = 1'b0;
            end else begin
              next_sda_oe = ~shift[7];
              next_shift  = {shift[6:0], 1'b0};
              next_cnt    = cnt + 4'h1;
            end
          end
        end
        cdr_regs_pkg::SS_RACK: begin
          if (scl_rise && sda) begin
            next_ss = cdr_regs_pkg::SS_IDLE;
          end else if (scl_fall) begin
            next_ss     = cdr_regs_pkg::SS_RD;
            next_sda_oe = ~rd_byte[7];
            next_shift  = {rd_byte[6:0], 1'b0};
            next_cnt    = 4'h1;
            next_ptr    = ptr + 8'h01;
          end
        end
        default: begin
          next_ss = cdr_regs_pkg::SS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ss       <= cdr_regs_pkg::SS_IDLE;
      ack_to   <= cdr_regs_pkg::SS_IDLE;
      shift    <= 8'h00;
      cnt      <= 4'h0;
      ptr      <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      ss       <= next_ss;
      ack_to   <= next_ack_to;
      shift    <= next_shift;
      cnt      <= next_cnt;
      ptr      <= next_ptr;
      sda_oe_o <= next_sda_oe;
      sda_o    <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // control registers, status and measurement
  // --------------------------------------------------------------
  logic [7:0]                next_rate_control;
  logic [7:0]                next_lock_reset_control;
  logic [7:0]                next_output_config;
  cdr_regs_pkg::rate_meas_t  next_meas_held;
  cdr_regs_pkg::status_t     next_status;
  cdr_regs_pkg::meas_state_t next_meas_state;
  logic                      next_meas_start;
  logic                      next_system_reset;
  logic                      live_prev;
  logic                      clr_static;
  logic                      clr_meas;
  logic                      sys_rst;
  logic                      lol_rise;

  always_comb begin
    next_rate_control       = rate_control;
    next_lock_reset_control = lock_reset_control;
    next_output_config      = output_config;
    next_meas_held          = meas_held;
    next_status             = status;
    next_meas_state         = meas_state;
    next_meas_start         = 1'b0;
    clr_static              = 1'b0;
    clr_meas                = 1'b0;
    sys_rst                 = 1'b0;
    if (wr_en && wr_addr == cdr_regs_pkg::OFS_RATE_CTRL) begin
      next_rate_control = wr_data;
      if (wr_data[cdr_regs_pkg::RC_MEASURE_BIT]) begin
        next_meas_start = 1'b1;
        next_meas_state = cdr_regs_pkg::MS_BUSY;
      end
    end else if (wr_en && wr_addr == cdr_regs_pkg::OFS_LOCK_CTRL) begin
      next_lock_reset_control = wr_data;
      clr_static = lock_reset_control[cdr_regs_pkg::LC_CLR_STAT_BIT]
                 & ~wr_data[cdr_regs_pkg::LC_CLR_STAT_BIT];
      clr_meas   = lock_reset_control[cdr_regs_pkg::LC_CLR_MEAS_BIT]
                 & ~wr_data[cdr_regs_pkg::LC_CLR_MEAS_BIT];
      sys_rst    = lock_reset_control[cdr_regs_pkg::LC_SYSRST_BIT]
                 & ~wr_data[cdr_regs_pkg::LC_SYSRST_BIT];
    end else if (wr_en && wr_addr == cdr_regs_pkg::OFS_OUT_CFG) begin
      next_output_config = wr_data;
    end
    case (meas_state)
      cdr_regs_pkg::MS_BUSY: begin
        if (meas_done_i) begin
          next_meas_held  = meas_i;
          next_meas_state = cdr_regs_pkg::MS_DONE;
        end
      end
      cdr_regs_pkg::MS_DONE: begin
        if (clr_meas) begin
          next_meas_state = cdr_regs_pkg::MS_IDLE;
        end
      end
      default: begin
      end
    endcase
    // lock detector with hysteresis
    if (freq_err_ppm_i > cdr_regs_pkg::UNLOCK_PPM) begin
      next_status.live_lol = 1'b1;
    end else if (freq_err_ppm_i <= cdr_regs_pkg::RELOCK_PPM) begin
      next_status.live_lol = 1'b0;
    end
    if (lol_rise) begin
      next_status.static_lol = 1'b1;
    end else if (clr_static) begin
      next_status.static_lol = 1'b0;
    end
    next_status.signal_absent_out       = signal_absent_out;
    next_status.meas_done = (next_meas_state == cdr_regs_pkg::MS_DONE);
    next_system_reset     = sys_rst;
    if (sys_rst) begin
      next_rate_control       = cdr_regs_pkg::CTRL_RESET;
      next_lock_reset_control = cdr_regs_pkg::CTRL_RESET;
      next_output_config      = cdr_regs_pkg::CTRL_RESET;
      next_meas_state         = cdr_regs_pkg::MS_IDLE;
      next_status.static_lol  = 1'b0;
      next_status.meas_done   = 1'b0;
      next_meas_start         = 1'b0;
    end
  end

  assign lol_rise = status.live_lol & ~live_prev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rate_control       <= cdr_regs_pkg::CTRL_RESET;
      lock_reset_control <= cdr_regs_pkg::CTRL_RESET;
      output_config      <= cdr_regs_pkg::CTRL_RESET;
      meas_held          <= '0;
      status             <= '0;
      meas_state         <= cdr_regs_pkg::MS_IDLE;
      meas_start_o       <= 1'b0;
      system_reset_o     <= 1'b0;
      live_prev          <= 1'b0;
    end else begin
      rate_control       <= next_rate_control;
      lock_reset_control <= next_lock_reset_control;
      output_config      <= next_output_config;
      meas_held          <= next_meas_held;
      status             <= next_status;
      meas_state         <= next_meas_state;
      meas_start_o       <= next_meas_start;
      system_reset_o     <= next_system_reset;
      live_prev          <= status.live_lol;
    end
  end

  // --------------------------------------------------------------
  // registered control outputs
  // --------------------------------------------------------------
  logic       next_unlocked;
  logic       next_los_pin;
  logic       next_clk_en;
  logic       next_data_en;

  always_comb begin
    next_unlocked = lock_reset_control[cdr_regs_pkg::LC_CFG_LOL_BIT]
                  ? status.static_lol : status.live_lol;
    next_los_pin  = status.signal_absent_out
                  ^ output_config[cdr_regs_pkg::OC_LOS_POL_BIT];
    next_data_en  = ~mute;
    next_clk_en   = ~(mute
                  & ~output_config[cdr_regs_pkg::OC_SQ_MODE_BIT]);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      refclk_band_o        <= 2'h0;
      ratio_exp_o          <= 4'h0;
      lock_to_ref_o        <= 1'b0;
      unlocked_indicator_o <= 1'b0;
      signal_absent_out_o  <= 1'b0;
      clk_out_en_o         <= 1'b1;
      data_out_en_o        <= 1'b1;
    end else begin
      refclk_band_o <= rate_control[cdr_regs_pkg::RC_BAND_HI:
                                    cdr_regs_pkg::RC_BAND_LO];
      ratio_exp_o   <= rate_control[cdr_regs_pkg::RC_EXP_HI:
                                    cdr_regs_pkg::RC_EXP_LO];
      lock_to_ref_o <= rate_control[cdr_regs_pkg::RC_LOCKREF_BIT];
      unlocked_indicator_o <= next_unlocked;
      signal_absent_out_o  <= next_los_pin;
      clk_out_en_o         <= next_clk_en;
      data_out_en_o        <= next_data_en;
    end
  end

endmodule

// ---- test/cdr_register_bank_sva.sv ----
`timescale 1ns/10ps
module cdr_register_bank_sva (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        sda_oe_o,
  input wire logic        mute_i,
  input wire logic [15:0] freq_err_ppm_i,
  input wire logic        meas_start_o,
  input wire logic [1:0]  refclk_band_o,
  input wire logic [3:0]  ratio_exp_o,
  input wire logic        lock_to_ref_o,
  input wire logic        unlocked_indicator_o,
  input wire logic        clk_out_en_o,
  input wire logic        data_out_en_o,
  input wire logic        system_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  meas_pulse_a: assert property (meas_start_o |=> !meas_start_o)
    else $error("measurement start longer than one cycle");
  meas_on_ack_a: assert property (meas_start_o |-> sda_oe_o)
    else $error("measurement start outside a data acknowledge");
  sysrst_pulse_a: assert property (
    system_reset_o |=> !system_reset_o)
    else $error("system reset longer than one cycle");
  sysrst_clear_a: assert property (system_reset_o |-> ##[0:3]
    (refclk_band_o == 2'h0 && ratio_exp_o == 4'h0 && !lock_to_ref_o))
    else $error("controls not cleared by system reset");
  ctrl_on_ack_a: assert property (
    $changed({refclk_band_o, ratio_exp_o, lock_to_ref_o}) |-> sda_oe_o)
    else $error("control outputs changed outside a write");
  unmute_en_a: assert property (
    !mute_i [*6] |-> clk_out_en_o && data_out_en_o)
    else $error("outputs disabled without mute");
  mute_data_a: assert property (mute_i [*6] |-> !data_out_en_o)
    else $error("data output not muted");
  unlock_ind_a: assert property (
    (freq_err_ppm_i > cdr_regs_pkg::UNLOCK_PPM) [*5] |->
    unlocked_indicator_o)
    else $error("unlocked indicator low with large error");

  cover property (meas_start_o);
  cover property (system_reset_o);
  cover property (mute_i && !clk_out_en_o);
endmodule

bind cdr_register_bank cdr_register_bank_sva cdr_register_bank_sva_i (
  .clk_i, .nrst_i, .sda_oe_o, .mute_i, .freq_err_ppm_i, .meas_start_o,
  .refclk_band_o, .ratio_exp_o, .lock_to_ref_o, .unlocked_indicator_o,
  .clk_out_en_o, .data_out_en_o, .system_reset_o);

// ---- test/i2c_host_model.sv ----
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  logic [7:0] rd_q [0:7];

  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // data set while clock low, sampled late in the clock-high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o <= ~b;
    wt(8);
    scl_o <= 1'b1;
    wt(6);
    r = sda_i;
    wt(2);
    scl_o <= 1'b0;
    wt(2);
  endtask

  task automatic start();
    sda_pull_o <= 1'b0;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    sda_pull_o <= 1'b1;
    wt(8);
    scl_o <= 1'b0;
    wt(2);
  endtask

  task automatic stop();
    sda_pull_o <= 1'b1;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    sda_pull_o <= 1'b0;
    wt(8);
  endtask

  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3;
    start();
    xfer(8'h60, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask

  // last byte answered with a not-acknowledge to end the burst
  task automatic read_regs(input logic [7:0] a, input int n);
    logic [7:0] q;
    logic       k;
    start();
    xfer(8'h60, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    start();
    xfer(8'h61, 1'b1, q, k);
    for (int i = 0; i < n; i++) xfer(8'hff, i == n - 1, rd_q[i], k);
    stop();
  endtask
endmodule

// ---- test/cdr_register_bank_bench.sv ----
`timescale 1ns/10ps
module cdr_register_bank_bench;
  logic                     clk_i = 1'b0;
  logic                     nrst_i = 1'b0;
  logic                     scl, sda_pull, sda_o, sda_oe_o, sda;
  logic                     addr5 = 1'b1;
  logic                     mute = 1'b0;
  logic                     lost = 1'b0;
  logic [15:0]              err = 16'h0000;
  logic                     mdone = 1'b0;
  cdr_regs_pkg::rate_meas_t meas = '0;
  logic                     mstart, lockref, unl, absent;
  logic                     clk_en, data_en, sysrst, ok;
  logic [1:0]               band;
  logic [3:0]               ratio;
  logic [7:0]               cw [0:3] = '{8'he1, 8'h54, 8'h89, 8'h20};
  int                       fails = 0;
  int                       samples_checked = 0;
  int                       cycles = 0;
  int                       n_meas = 0;
  int                       n_rst = 0;

  always #4 clk_i = ~clk_i;
  // open-drain line with pull-up
  assign sda = !sda_pull && !(sda_oe_o && !sda_o);

  i2c_host_model i2c_host_model_i (.clk_i, .sda_i(sda), .scl_o(scl),
    .sda_pull_o(sda_pull));
  cdr_register_bank cdr_register_bank_i (.clk_i, .nrst_i, .scl_i(scl),
    .sda_i(sda), .sda_o, .sda_oe_o, .slave_addr_bit5_pin_i(addr5),
    .mute_i(mute), .signal_lost_i(lost), .freq_err_ppm_i(err),
    .meas_done_i(mdone), .meas_i(meas), .meas_start_o(mstart),
    .refclk_band_o(band), .ratio_exp_o(ratio), .lock_to_ref_o(lockref),
    .unlocked_indicator_o(unl), .signal_absent_out_o(absent),
    .clk_out_en_o(clk_en), .data_out_en_o(data_en),
    .system_reset_o(sysrst));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i2c_host_model_i.write_reg(a, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    i2c_host_model_i.read_regs(a, 1);
    chk(i2c_host_model_i.rd_q[0] & m, e);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (mstart === 1'b1) n_meas++;
    if (sysrst === 1'b1) n_rst++;
    if (cycles == 60000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({5'h00, absent, clk_en, data_en}, 8'h03);
    repeat (2) @(posedge clk_i);
    rd(8'h08, 8'hff, 8'h00);
    rd(8'h09, 8'hff, 8'h00);
    rd(8'h11, 8'hff, 8'h00);
    rd(8'h05, 8'hff, 8'h00);
    chk({band, ratio, 1'b0, lockref}, 8'h00);
    foreach (cw[i]) begin
      wr(8'h08, cw[i]);
      chk({band, ratio, 1'b0, lockref}, cw[i]);
    end
    rd(8'h04, 8'h04, 8'h00);
    wr(8'h08, 8'h02);
    chk(8'(n_meas), 8'h01);
    meas <= {23'h4ab3c5, 9'h1a5};
    mdone <= 1'b1;
    @(posedge clk_i);
    mdone <= 1'b0;
    i2c_host_model_i.write_reg(8'h03, 8'hff, ok);
    i2c_host_model_i.read_regs(8'h00, 5);
    chk(i2c_host_model_i.rd_q[0], 8'hc5);
    chk(i2c_host_model_i.rd_q[1], 8'hb3);
    chk(i2c_host_model_i.rd_q[2], 8'h4a);
    chk(i2c_host_model_i.rd_q[3], 8'hd2);
    chk(i2c_host_model_i.rd_q[4] & 8'h3d, 8'h05);
    wr(8'h09, 8'h08);
    wr(8'h09, 8'h00);
    rd(8'h04, 8'h04, 8'h00);
    lost <= 1'b1;
    err <= 16'h03e8;
    rd(8'h04, 8'h38, 8'h20);
    err <= 16'h03e9;
    rd(8'h04, 8'h38, 8'h38);
    chk({7'h00, unl}, 8'h01);
    err <= 16'h0258;
    rd(8'h04, 8'h38, 8'h38);
    err <= 16'h00fa;
    rd(8'h04, 8'h38, 8'h30);
    chk({7'h00, unl}, 8'h00);
    wr(8'h09, 8'h80);
    chk({7'h00, unl}, 8'h01);
    wr(8'h09, 8'hc0);
    wr(8'h09, 8'h80);
    rd(8'h04, 8'h38, 8'h20);
    chk({7'h00, unl}, 8'h00);
    mute <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({5'h00, absent, clk_en, data_en}, 8'h04);
    wr(8'h11, 8'h06);
    chk({5'h00, absent, clk_en, data_en}, 8'h02);
    mute <= 1'b0;
    lost <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({5'h00, absent, clk_en, data_en}, 8'h07);
    wr(8'h08, 8'he1);
    wr(8'h09, 8'h20);
    wr(8'h09, 8'h00);
    chk(8'(n_rst), 8'h01);
    chk({band, ratio, 1'b0, lockref}, 8'h00);
    addr5 <= 1'b0;
    i2c_host_model_i.write_reg(8'h08, 8'he1, ok);
    chk({7'h00, ok}, 8'h00);
    chk({band, ratio, 1'b0, lockref}, 8'h00);
    give_verdict();
  end
endmodule
